// *** common/drive_map_regs.vh ***
`ifndef DRIVE_MAP_REGS_VH
`define DRIVE_MAP_REGS_VH

// register byte offsets, one aligned 32-bit word each
`define OFS_IN_WORD3_SEL 8'h00
`define OFS_IN_WORD4_SEL 8'h04
`define OFS_OUT_WORD3_SEL 8'h08
`define OFS_OUT_WORD4_SEL 8'h0c
`define OFS_TORQUE_SRC 8'h10
`define OFS_MAX_TORQUE 8'h14
`define OFS_MAX_SPEED 8'h18
`define OFS_PID_SRC 8'h1c
`define OFS_RAMP_EN 8'h20
`define OFS_USER_MON 8'h24
`define OFS_USER_REG1 8'h28
`define OFS_USER_REG2 8'h2c
`define OFS_USER_REG3 8'h30
`define OFS_USER_REG4 8'h34
`define OFS_FREQ_SETP 8'h38
`define OFS_XCHG_CNT 8'h3c

// reset values
`define RST_MAX_TORQUE 16'h07d0
`define RST_MAX_SPEED 16'h1388

// selector codes
`define IN3_TORQUE 2'h0
`define IN3_PID 2'h1
`define IN3_USER3 2'h2
`define IN4_RAMP 2'h0
`define IN4_USER4 2'h1
`define TORQUE_SRC_BUS 3'h3
`define PID_SRC_BUS 2'h1

// value limits in 0.1 units
`define SETP_LIMIT 16'h1388
`define TORQUE_LIMIT 16'h07d0

// status byte field positions
`define ST_RUN 0
`define ST_TRIP 1
`define ST_MAINT 2
`define ST_STO 3

`endif

// *** hw/out_word_select.v ***
`timescale 1ns/100ps
// ---------------------------------------------------------------
// eight-way selectable monitoring word
// ---------------------------------------------------------------
module out_word_select
(
  input wire [2:0] sel,
  input wire [15:0] src0,
  input wire [15:0] src1,
  input wire [15:0] src2,
  input wire [15:0] src3,
  input wire [15:0] src4,
  input wire [15:0] src5,
  input wire [15:0] src6,
  input wire [15:0] src7,
  output reg [15:0] word
);

  always @*
  begin
    case (sel)
      3'h0: word = src0;
      3'h1: word = src1;
      3'h2: word = src2;
      3'h3: word = src3;
      3'h4: word = src4;
      3'h5: word = src5;
      3'h6: word = src6;
      3'h7: word = src7;
      default: word = 16'h0000;
    endcase
  end

endmodule // out_word_select

// *** hw/drive_process_data_mapper.v ***
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`include "drive_map_regs.vh"
// Behaviour
// - four 16-bit words to the master and three (words 2..4) from it are exchanged on every exchange strobe.
// - input word 2 is a signed frequency setpoint in 0.1 Hz.
// - setpoint held within +-5000, then within the maximum speed setting.
// - input word 3 routes to torque, PID setpoint or user register 3.
// - torque word is unsigned 0..2000, needs torque source 3, capped by max torque.
// - word 3 becomes PID setpoint only when PID source setting is 1.
// - selector 2 copies input word 3 into read-only user register 3.
// - input word 4 routes to ramp control or user register 4.
// - ramp control from word 4 only when ramp source enable is 1.
// - selector 1 copies input word 4 into user register 4.
// - output word 1 high byte is the fault code, valid when tripped.
// - status low byte: run bit 0, trip bit 1, maintenance bit 2, 4..7 zero.
// - status bit 3 set while safe torque off enables are absent.
// - output word 2 is the signed output frequency in 0.1 Hz.
// - output word 3 codes 0..4: current, power, inputs, analog 2, heatsink.
// - output word 3 codes 5..7: user register 1, 2, user monitor value.
// - input bitmap bit 0 is digital input 1, upward.
// - output word 4 codes 0..4: torque, power, inputs, analog 2, heatsink.
module drive_process_data_mapper
(
  input wire clk_sys,
  input wire sys_rst,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // cyclic word buffer side
  input wire xchg_strobe,
  input wire [15:0] master_to_drive_word2,
  input wire [15:0] master_to_drive_word3,
  input wire [15:0] master_to_drive_word4,
  output reg [15:0] drive_to_master_word1,
  output reg [15:0] drive_to_master_word2,
  output reg [15:0] drive_to_master_word3,
  output reg [15:0] drive_to_master_word4,
  output reg xchg_done,
  // drive state
  input wire drive_running,
  input wire drive_tripped,
  input wire maint_due,
  input wire safe_torque_off_inhibit,
  input wire [7:0] fault_code,
  input wire [15:0] out_freq,
  input wire [15:0] motor_current,
  input wire [15:0] out_power,
  input wire [15:0] out_torque,
  input wire [15:0] dig_inputs,
  input wire [15:0] analog_in2,
  input wire [15:0] heatsink_temp,
  // decoded commands to the drive
  output reg [15:0] freq_setpoint,
  output reg [15:0] torque_ref,
  output reg torque_ref_valid,
  output reg [15:0] pid_setpoint,
  output reg pid_setpoint_valid,
  output reg [15:0] ramp_time,
  output reg ramp_time_valid,
  output reg [15:0] user_reg3,
  output reg [15:0] user_reg4
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // signed clamp to +-lim, lim taken as unsigned magnitude
  function [15:0] clamp_signed;
    input [15:0] v;
    input [15:0] lim;
    reg [15:0] mag;
    begin
      mag = v[15] ? (16'h0000 - v) : v;
      if (mag > lim)
        clamp_signed = v[15] ? (16'h0000 - lim) : lim;
      else
        clamp_signed = v;
    end
  endfunction

  function [15:0] min16;
    input [15:0] a;
    input [15:0] b;
    begin
      min16 = (a < b) ? a : b;
    end
  endfunction

  // merge a write under byte enables
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer i;
    begin
      be_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          be_merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  reg [1:0] in_word3_selector_q;
  reg [1:0] in_word4_selector_q;
  reg [2:0] out_word3_selector_q;
  reg [2:0] out_word4_selector_q;
  reg [2:0] torque_source_select_q;
  reg [15:0] max_torque_limit_q;
  reg [15:0] max_speed_limit_q;
  reg [1:0] pid_setpoint_source_q;
  reg ramp_source_enable_q;
  reg [15:0] user_monitor_value_q;
  reg [15:0] user_reg1_q;
  reg [15:0] user_reg2_q;
  reg [15:0] xchg_cnt_q;

  wire wr_take = avs_write & ~avs_waitrequest;
  wire [31:0] wr_word = be_merge(32'h00000000, avs_writedata, avs_byteenable);
  reg [31:0] rd_d;

  always @*
  begin
    case (avs_address)
      `OFS_IN_WORD3_SEL: rd_d = {30'h0, in_word3_selector_q};
      `OFS_IN_WORD4_SEL: rd_d = {30'h0, in_word4_selector_q};
      `OFS_OUT_WORD3_SEL: rd_d = {29'h0, out_word3_selector_q};
      `OFS_OUT_WORD4_SEL: rd_d = {29'h0, out_word4_selector_q};
      `OFS_TORQUE_SRC: rd_d = {29'h0, torque_source_select_q};
      `OFS_MAX_TORQUE: rd_d = {16'h0, max_torque_limit_q};
      `OFS_MAX_SPEED: rd_d = {16'h0, max_speed_limit_q};
      `OFS_PID_SRC: rd_d = {30'h0, pid_setpoint_source_q};
      `OFS_RAMP_EN: rd_d = {31'h0, ramp_source_enable_q};
      `OFS_USER_MON: rd_d = {16'h0, user_monitor_value_q};
      `OFS_USER_REG1: rd_d = {16'h0, user_reg1_q};
      `OFS_USER_REG2: rd_d = {16'h0, user_reg2_q};
      `OFS_USER_REG3: rd_d = {16'h0, user_reg3};
      `OFS_USER_REG4: rd_d = {16'h0, user_reg4};
      `OFS_FREQ_SETP: rd_d = {16'h0, freq_setpoint};
      `OFS_XCHG_CNT: rd_d = {16'h0, xchg_cnt_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  // one wait state on every access; read data is captured as waitrequest drops
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else if (avs_waitrequest && (avs_read || avs_write))
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? rd_d : 32'h00000000;
    end
    else
      avs_waitrequest <= 1'b1;
  end

  // user registers 3 and 4 and the setpoint are bus-owned, hence read only here
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      in_word3_selector_q <= 2'h0;
      in_word4_selector_q <= 2'h0;
      out_word3_selector_q <= 3'h0;
      out_word4_selector_q <= 3'h0;
      torque_source_select_q <= 3'h0;
      max_torque_limit_q <= `RST_MAX_TORQUE;
      max_speed_limit_q <= `RST_MAX_SPEED;
      pid_setpoint_source_q <= 2'h0;
      ramp_source_enable_q <= 1'b0;
      user_monitor_value_q <= 16'h0000;
      user_reg1_q <= 16'h0000;
      user_reg2_q <= 16'h0000;
    end
    else if (wr_take)
    begin
      case (avs_address)
        `OFS_IN_WORD3_SEL: in_word3_selector_q <= wr_word[1:0];
        `OFS_IN_WORD4_SEL: in_word4_selector_q <= wr_word[1:0];
        `OFS_OUT_WORD3_SEL: out_word3_selector_q <= wr_word[2:0];
        `OFS_OUT_WORD4_SEL: out_word4_selector_q <= wr_word[2:0];
        `OFS_TORQUE_SRC: torque_source_select_q <= wr_word[2:0];
        `OFS_MAX_TORQUE: max_torque_limit_q <= wr_word[15:0];
        `OFS_MAX_SPEED: max_speed_limit_q <= wr_word[15:0];
        `OFS_PID_SRC: pid_setpoint_source_q <= wr_word[1:0];
        `OFS_RAMP_EN: ramp_source_enable_q <= wr_word[0];
        `OFS_USER_MON: user_monitor_value_q <= wr_word[15:0];
        `OFS_USER_REG1: user_reg1_q <= wr_word[15:0];
        `OFS_USER_REG2: user_reg2_q <= wr_word[15:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output word assembly
  // ---------------------------------------------------------------
  // both muxes read the selector registers directly; results are only
  // captured on the strobe, so one selection shapes each exchange
  wire [15:0] word3_sel;
  wire [15:0] word4_sel;

  out_word_select u_word3
  (
    .sel(out_word3_selector_q),
    .src0(motor_current),
    .src1(out_power),
    .src2(dig_inputs),
    .src3(analog_in2),
    .src4(heatsink_temp),
    .src5(user_reg1_q),
    .src6(user_reg2_q),
    .src7(user_monitor_value_q),
    .word(word3_sel)
  );

  out_word_select u_word4
  (
    .sel(out_word4_selector_q),
    .src0(out_torque),
    .src1(out_power),
    .src2(dig_inputs),
    .src3(analog_in2),
    .src4(heatsink_temp),
    .src5(16'h0000),
    .src6(16'h0000),
    .src7(16'h0000),
    .word(word4_sel)
  );

  wire [7:0] status_byte;
  assign status_byte[`ST_RUN] = drive_running;
  assign status_byte[`ST_TRIP] = drive_tripped;
  assign status_byte[`ST_MAINT] = maint_due;
  assign status_byte[`ST_STO] = safe_torque_off_inhibit;
  assign status_byte[7:4] = 4'h0;

  // fault byte is zeroed while healthy so stale codes never reach the master
  wire [7:0] fault_byte = drive_tripped ? fault_code : 8'h00;

  // ---------------------------------------------------------------
  // input word decode
  // ---------------------------------------------------------------
  // negative values arrive as two's complement and pass the clamp unchanged in sign
  wire [15:0] setp_lim = min16(`SETP_LIMIT, max_speed_limit_q);
  wire [15:0] setp_d = clamp_signed(master_to_drive_word2, setp_lim);
  wire [15:0] torque_d = min16(min16(master_to_drive_word3, `TORQUE_LIMIT),
    max_torque_limit_q);
  wire torque_en = (in_word3_selector_q == `IN3_TORQUE) &&
    (torque_source_select_q == `TORQUE_SRC_BUS);
  wire pid_en = (in_word3_selector_q == `IN3_PID) &&
    (pid_setpoint_source_q == `PID_SRC_BUS);
  wire user3_en = (in_word3_selector_q == `IN3_USER3);
  wire ramp_en = (in_word4_selector_q == `IN4_RAMP) && ramp_source_enable_q;
  wire user4_en = (in_word4_selector_q == `IN4_USER4);

  // ---------------------------------------------------------------
  // exchange cycle
  // ---------------------------------------------------------------
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      drive_to_master_word1 <= 16'h0000;
      drive_to_master_word2 <= 16'h0000;
      drive_to_master_word3 <= 16'h0000;
      drive_to_master_word4 <= 16'h0000;
      xchg_done <= 1'b0;
      xchg_cnt_q <= 16'h0000;
      freq_setpoint <= 16'h0000;
      torque_ref <= 16'h0000;
      torque_ref_valid <= 1'b0;
      pid_setpoint <= 16'h0000;
      pid_setpoint_valid <= 1'b0;
      ramp_time <= 16'h0000;
      ramp_time_valid <= 1'b0;
      user_reg3 <= 16'h0000;
      user_reg4 <= 16'h0000;
    end
    else
    begin
      xchg_done <= xchg_strobe;
      if (xchg_strobe)
      begin
        xchg_cnt_q <= xchg_cnt_q + 16'h0001;
        drive_to_master_word1 <= {fault_byte, status_byte};
        drive_to_master_word2 <= out_freq;
        drive_to_master_word3 <= word3_sel;
        drive_to_master_word4 <= word4_sel;
        freq_setpoint <= setp_d;
        // a disabled route keeps its last value; valid flags tell the drive
        torque_ref_valid <= torque_en;
        if (torque_en)
          torque_ref <= torque_d;
        pid_setpoint_valid <= pid_en;
        if (pid_en)
          pid_setpoint <= master_to_drive_word3;
        if (user3_en)
          user_reg3 <= master_to_drive_word3;
        ramp_time_valid <= ramp_en;
        if (ramp_en)
          ramp_time <= master_to_drive_word4;
        if (user4_en)
          user_reg4 <= master_to_drive_word4;
      end
    end
  end

endmodule // drive_process_data_mapper

// *** testbench/fieldbus_master_model.sv ***
`timescale 1ns/100ps
module fieldbus_master_model
(
  input logic clk_sys,
  output logic xchg_strobe,
  output logic [15:0] master_to_drive_word2,
  output logic [15:0] master_to_drive_word3,
  output logic [15:0] master_to_drive_word4
);
  initial
  begin
    xchg_strobe = 1'b0;
    {master_to_drive_word2, master_to_drive_word3, master_to_drive_word4} = '0;
  end
  // words are inverted after the strobe so nothing can lean on stale data
  task send(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    xchg_strobe <= 1'b1;
    master_to_drive_word2 <= a;
    master_to_drive_word3 <= b;
    master_to_drive_word4 <= c;
    @(posedge clk_sys);
    xchg_strobe <= 1'b0;
    {master_to_drive_word2, master_to_drive_word3, master_to_drive_word4} <= ~{a, b, c};
    @(posedge clk_sys);
  endtask
endmodule // fieldbus_master_model

// *** testbench/drive_map_chk.sv ***
`timescale 1ns/100ps
module drive_map_chk
(
  input logic clk_sys,
  input logic sys_rst,
  input logic xchg_strobe,
  input logic xchg_done,
  input logic drive_running,
  input logic drive_tripped,
  input logic maint_due,
  input logic safe_torque_off_inhibit,
  input logic [7:0] fault_code,
  input logic [15:0] out_freq,
  input logic [15:0] drive_to_master_word1,
  input logic [15:0] drive_to_master_word2,
  input logic [15:0] freq_setpoint,
  input logic [15:0] torque_ref,
  input logic torque_ref_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire [15:0] w1 = drive_to_master_word1;
  wire [7:0] st = {4'h0, safe_torque_off_inhibit, maint_due, drive_tripped, drive_running};
  chk_done_pulse: assert property (xchg_strobe |=> xchg_done)
    else $error("done missing after strobe");
  chk_done_cause: assert property (xchg_done |-> $past(xchg_strobe))
    else $error("done without strobe");
  chk_status_low: assert property (xchg_strobe |=> w1[7:0] == $past(st))
    else $error("status byte wrong");
  chk_fault_byte: assert property (xchg_strobe |=>
    w1[15:8] == ($past(drive_tripped) ? $past(fault_code) : 8'h00))
    else $error("fault byte wrong");
  chk_freq_word: assert property (xchg_strobe |=> drive_to_master_word2 == $past(out_freq))
    else $error("frequency word wrong");
  chk_words_hold: assert property (!xchg_strobe |=> $stable(w1) && $stable(drive_to_master_word2))
    else $error("words moved without strobe");
  chk_setp_range: assert property (xchg_done |->
    $signed(freq_setpoint) <= 16'sd5000 && $signed(freq_setpoint) >= -16'sd5000)
    else $error("setpoint out of range");
  chk_torque_cap: assert property (torque_ref_valid |-> torque_ref <= 16'h07d0)
    else $error("torque above limit");
  cp_trip: cover property (xchg_strobe && drive_tripped);
  cp_torque: cover property (xchg_done && torque_ref_valid);
  cp_sto: cover property (xchg_strobe && safe_torque_off_inhibit);
endmodule // drive_map_chk

bind drive_process_data_mapper drive_map_chk chk_i (.clk_sys, .sys_rst, .xchg_strobe,
  .xchg_done, .drive_running, .drive_tripped, .maint_due, .safe_torque_off_inhibit,
  .fault_code, .out_freq, .drive_to_master_word1, .drive_to_master_word2, .freq_setpoint,
  .torque_ref, .torque_ref_valid);

// *** testbench/drive_process_data_mapper_tb.sv ***
`timescale 1ns/100ps
module drive_process_data_mapper_tb;
  logic clk_sys = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic [7:0] avs_address = 0, fault_code = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0] avs_byteenable = 4'hf;
  logic drive_running = 0, drive_tripped = 0, maint_due = 0, safe_torque_off_inhibit = 0;
  logic [15:0] out_freq = 0, motor_current = 0, out_power = 0, out_torque = 0;
  logic [15:0] dig_inputs = 0, analog_in2 = 0, heatsink_temp = 0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, xchg_strobe, xchg_done, torque_ref_valid, pid_setpoint_valid;
  wire ramp_time_valid;
  wire [15:0] master_to_drive_word2, master_to_drive_word3, master_to_drive_word4;
  wire [15:0] drive_to_master_word1, drive_to_master_word2, drive_to_master_word3;
  wire [15:0] drive_to_master_word4, freq_setpoint, torque_ref, pid_setpoint, ramp_time;
  wire [15:0] user_reg3, user_reg4;
  typedef logic [10:0][15:0] exp_t;
  exp_t eq[$];
  logic [31:0] rq[$];
  logic [15:0] r[16];
  logic [15:0] tr_q = 0, pd_q = 0, rp_q = 0, u3_q = 0, u4_q = 0, sp_q = 0;
  logic [15:0] setp[8] = '{16'h01f4, 16'hffff, 16'hff16, 16'h1388, 16'h1389, 16'hec78,
    16'hec77, 16'h8000};
  int err_count = 0, checked = 0, i;

  always #5 clk_sys = ~clk_sys;

  drive_process_data_mapper uut (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .xchg_strobe,
    .master_to_drive_word2, .master_to_drive_word3, .master_to_drive_word4,
    .drive_to_master_word1, .drive_to_master_word2, .drive_to_master_word3,
    .drive_to_master_word4, .xchg_done, .drive_running, .drive_tripped, .maint_due,
    .safe_torque_off_inhibit, .fault_code, .out_freq, .motor_current, .out_power, .out_torque,
    .dig_inputs, .analog_in2, .heatsink_temp, .freq_setpoint, .torque_ref, .torque_ref_valid,
    .pid_setpoint, .pid_setpoint_valid, .ramp_time, .ramp_time_valid, .user_reg3, .user_reg4);

  fieldbus_master_model m (.clk_sys, .xchg_strobe, .master_to_drive_word2,
    .master_to_drive_word3, .master_to_drive_word4);

  // ---------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------
  task cmp16(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t word got %h exp %h", $time, g, e);
    end
  endtask

  task cmp32(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t read got %h exp %h", $time, g, e);
    end
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // avalon master, one request held until waitrequest is seen low
  // ---------------------------------------------------------------
  task ack;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= 1'b1;
    ack;
    avs_write <= 1'b0;
    if (a < 8'h30)
      r[a[5:2]] = d;
    @(posedge clk_sys);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    avs_address <= a;
    avs_read <= 1'b1;
    ack;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  always @(posedge clk_sys)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() > 0)
      cmp32(avs_readdata, rq.pop_front());

  // ---------------------------------------------------------------
  // exchange: drive state, expectation, then the master's frame
  // ---------------------------------------------------------------
  task xchg(input logic [15:0] w2, input logic [15:0] w3, input logic [15:0] w4);
    logic [3:0] st;
    logic [7:0] fc;
    logic [15:0] s[8];
    logic [15:0] o3, o4;
    logic tv, pv, rv;
    int v, l;
    st = $urandom;
    fc = $urandom;
    foreach (s[k]) s[k] = $urandom;
    {safe_torque_off_inhibit, maint_due, drive_tripped, drive_running} <= st;
    fault_code <= fc;
    {motor_current, out_power, dig_inputs, analog_in2} <= {s[0], s[1], s[2], s[3]};
    {heatsink_temp, out_freq, out_torque} <= {s[4], s[5], s[6]};
    o3 = r[2][2:0] < 5 ? s[r[2][2:0]] : r[2][2:0] == 5 ? r[10] : r[2][2:0] == 6 ? r[11] : r[9];
    o4 = r[3][2:0] == 0 ? s[6] : r[3][2:0] < 5 ? s[r[3][2:0]] : 16'h0;
    l = r[6] < 16'h1388 ? r[6] : 16'h1388;
    v = $signed(w2);
    v = v > l ? l : v < -l ? -l : v;
    sp_q = v[15:0];
    tv = r[0][1:0] == 0 && r[4][2:0] == 3;
    pv = r[0][1:0] == 1 && r[7][1:0] == 1;
    rv = r[1][1:0] == 0 && r[8][0];
    if (tv)
      tr_q = w3 > 16'h07d0 ? (r[5] < 16'h07d0 ? r[5] : 16'h07d0) : (w3 > r[5] ? r[5] : w3);
    if (pv)
      pd_q = w3;
    if (rv)
      rp_q = w4;
    if (r[0][1:0] == 2)
      u3_q = w3;
    if (r[1][1:0] == 1)
      u4_q = w4;
    eq.push_back({st[1] ? fc : 8'h00, 4'h0, st, s[5], o3, o4, v[15:0], u3_q, u4_q,
      {13'h0, tv, pv, rv}, tr_q, pd_q, rp_q});
    m.send(w2, w3, w4);
  endtask

  always @(negedge clk_sys)
    if (xchg_done === 1'b1)
    begin : mon
      exp_t e, g;
      g = {drive_to_master_word1, drive_to_master_word2, drive_to_master_word3,
        drive_to_master_word4, freq_setpoint, user_reg3, user_reg4,
        {13'h0, torque_ref_valid, pid_setpoint_valid, ramp_time_valid}, torque_ref,
        pid_setpoint, ramp_time};
      e = eq.size() > 0 ? eq.pop_front() : ~g;
      for (int k = 0; k < 11; k++) cmp16(g[k], e[k]);
    end

  initial
  begin
    #100us;
    err_count++;
    $display("[ERR] %0t timeout", $time);
    stop_test;
  end

  initial
  begin
    void'($urandom(40));
    foreach (r[k]) r[k] = 16'h0;
    r[5] = 16'h07d0;
    r[6] = 16'h1388;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'h14, 32'h07d0);
    rd(8'h18, 32'h1388);
    rd(8'h0c, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h30, 16'h1234);
    rd(8'h30, 32'h0);
    $display("test registers done");
    wr(8'h24, $urandom);
    wr(8'h28, $urandom);
    wr(8'h2c, $urandom);
    for (i = 0; i < 40; i++)
    begin
      wr(8'h00, 16'(i % 4));
      wr(8'h04, 16'(i / 4 % 4));
      wr(8'h08, 16'(i % 8));
      wr(8'h0c, 16'(i / 2 % 8));
      wr(8'h10, i / 4 % 2 ? 16'h3 : 16'h1);
      wr(8'h1c, 16'(i / 8 % 2));
      wr(8'h20, 16'(i % 2));
      if (i == 20)
      begin
        wr(8'h18, 16'h03e8);
        wr(8'h14, 16'h01f4);
      end
      xchg(setp[i % 8], i % 3 == 0 ? 16'h07d1 : 16'($urandom), 16'($urandom));
    end
    $display("test exchange done");
    rd(8'h30, {16'h0, u3_q});
    rd(8'h34, {16'h0, u4_q});
    rd(8'h38, {16'h0, sp_q});
    rd(8'h3c, 32'h28);
    $display("test readback done");
    stop_test;
  end
endmodule // drive_process_data_mapper_tb
